/* lowside_consts.svh */
// Constants of the low-side switch status register block.
// Included by every file that uses its macros; holds definitions only.
`ifndef LOWSIDE_CONSTS_SVH
`define LOWSIDE_CONSTS_SVH

// ---------------------------------------------------------------
// Serial command codes
// ---------------------------------------------------------------
`define READ_IDENTIFIER_CMD      8'h01
`define READ_REVISION_CMD        8'h02
`define READ_INPUTS_LOW_CMD      8'h03
`define READ_INPUTS_HIGH_CMD     8'h04
`define WRITE_SUPPLY_CONFIG_CMD  8'h05
`define READ_SUPPLY_STATUS_CMD   8'h06
`define CLEAR_DIAG_CMD           8'h07
`define WRITE_BUS_CONFIG_CMD     8'h08
`define READ_BUS_CONFIG_CMD      8'h09
`define READ_DIAG_BASE_CMD       8'h10
`define DIAG_REG_COUNT           3'h5

// ---------------------------------------------------------------
// Field positions of the supply status/configuration and bus configuration registers
// ---------------------------------------------------------------
`define STAT_OV_BIT              0
`define STAT_UV_BIT              1
`define STAT_ENABLE_BIT          2
`define STAT_ERROR_BIT           3
`define STAT_OT_BIT              4
`define CFG_LATCH_BIT            5
`define CFG_SELECT_BIT           6
`define CFG_DISABLE_BIT          7
`define BUS_MUX_BIT              1

// ---------------------------------------------------------------
// Reset values and frame timing
// ---------------------------------------------------------------
`define SUPPLY_CFG_RESET         3'h7
`define BUS_CFG_RESET            7'h7f
`define DIAG_BITS                36
`define DIAG_RESET               36'hf_ffff_ffff
`define STAGE_OK                 2'h3
`define CMD_BITS                 5'h08
`define FRAME_BITS               5'h10

`endif

/* lowside_pkg.sv */
// Types shared by the low-side switch status register block.
// Needs nothing from its surroundings.
package lowside_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [4:0] bit_count_t;
  typedef logic [1:0] stage_code_t;
endpackage

/* diag_register_bank.sv */
// Bank of five diagnostic registers with sticky fault capture.
// Expects all inputs already synchronous to clk_in.
`timescale 1ns/100ps
`include "lowside_consts.svh"

module diag_register_bank (
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  input  wire logic                   soft_rst_in,
  input  wire logic                   clear_in,
  input  wire logic [`DIAG_BITS-1:0]  code_in,
  input  wire logic                   ubatt_ok_in,
  input  wire logic [2:0]             addr_in,
  output logic      [7:0]             rdata_out,
  output logic                        any_error_out
);

  logic [`DIAG_BITS-1:0] store;

  // ---------------------------------------------------------------
  // Per-stage capture
  // ---------------------------------------------------------------
  // A stage keeps its last fault code until a clear finds the input
  // healthy or soft_rst_in resets it; a clear while the fault persists reloads the fault.
  genvar g;
  generate
    for (g = 0; g < `DIAG_BITS / 2; g++) begin : g_stage
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          store[2*g+1:2*g] <= `STAGE_OK;
        end else if (soft_rst_in) begin
          store[2*g+1:2*g] <= `STAGE_OK;
        end else if (clear_in || code_in[2*g+1:2*g] != `STAGE_OK) begin
          store[2*g+1:2*g] <= code_in[2*g+1:2*g];
        end
      end

      a_fault_keep: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (clear_in && !soft_rst_in && code_in[2*g+1:2*g] != `STAGE_OK)
        |=> store[2*g+1:2*g] == $past(code_in[2*g+1:2*g]))
        else $error("clear dropped a fault that is still present");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read port and summary flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'hff;
    end else if (addr_in < 3'h4) begin
      rdata_out <= store[{addr_in, 3'h0} +: 8];
    end else if (addr_in == 3'h4) begin
      rdata_out <= {3'h7, ubatt_ok_in, store[`DIAG_BITS-1:32]};
    end else begin
      rdata_out <= 8'hff;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      any_error_out <= 1'b0;
    end else begin
      any_error_out <= (store != `DIAG_RESET);
    end
  end

  a_clear_ones: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (clear_in && code_in == `DIAG_RESET) |=> store == `DIAG_RESET)
    else $error("clear with healthy inputs did not set all ones");

  a_fault_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (store != `DIAG_RESET && !clear_in && !soft_rst_in)
    |=> ##1 any_error_out)
    else $error("stored fault vanished without a clear");

endmodule // diag_register_bank

/* lowside_switch_status_regs.sv */
// Serial-reachable status and configuration registers of a
// low-side switch: identifier, revision, input readback, supply
// status/configuration, bus configuration and diagnostics clear.
// Assumes an SPI master in mode 0 with 16-bit frames, command byte
// first; all pins are asynchronous and are sampled by clk_in.
`timescale 1ns/100ps
`include "lowside_consts.svh"

module lowside_switch_status_regs #(
  parameter logic [7:0] CHIP_ID  = 8'h5a, // Arbitrary value.
  parameter logic [3:0] SW_REV   = 4'h3,  // Arbitrary value.
  parameter logic [3:0] MASK_REV = 4'h2   // Arbitrary value.
) (
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  reset_pin_n_in,
  input  wire logic                  spi_sclk_in,
  input  wire logic                  spi_ncs_in,
  input  wire logic                  spi_mosi_in,
  output logic                       spi_miso_out,
  output logic                       spi_miso_oe_out,
  input  wire logic [4:0]            par_in_low_in,
  input  wire logic                  parallel_input_eight_in,
  input  wire logic [6:0]            par_in_high_in,
  input  wire logic                  serial_bus_test_bit_in,
  input  wire logic                  overvoltage_in,
  input  wire logic                  undervoltage_in,
  input  wire logic                  ubatt_ok_in,
  input  wire logic [17:0]           overtemperature_in,
  input  wire logic [`DIAG_BITS-1:0] stage_code_in,
  input  wire logic                  enable_pin_in,
  output logic                       enable_pin_out,
  output logic                       enable_pin_oe_out,
  output logic                       pullup_enable_out,
  output logic                       bus_multiplex_select_out,
  output logic [5:0]                 scb_shutoff_out,
  output logic                       threshold_test_enable_out,
  output logic                       threshold_test_select_out,
  output logic                       stage_retry_out
);

  localparam int SYNC_W = 76;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Every pin passes two flip-flops; the chip select resets high so
  // that no frame appears to start while the device comes out of
  // reset.
  logic [SYNC_W-1:0]          sync_a;
  logic [SYNC_W-1:0]          sync_b;
  logic [`DIAG_BITS-1:0]      code_s;
  logic [17:0]                ot_s;
  logic [4:0]                 inl_s;
  logic                       in8_s;
  logic [6:0]                 inh_s;
  logic                       test_s;
  logic                       ov_s;
  logic                       uv_s;
  logic                       ubatt_s;
  logic                       abe_s;
  logic                       rstpin_s;
  logic                       mosi_s;
  logic                       sclk_s;
  logic                       ncs_s;
  logic                       sclk_d;
  logic                       ncs_d;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a <= {{(SYNC_W-1){1'b0}}, 1'b1};
      sync_b <= {{(SYNC_W-1){1'b0}}, 1'b1};
    end else begin
      sync_a <= {stage_code_in, overtemperature_in, par_in_low_in,
                 parallel_input_eight_in, par_in_high_in,
                 serial_bus_test_bit_in, overvoltage_in,
                 undervoltage_in, ubatt_ok_in, enable_pin_in,
                 reset_pin_n_in, spi_mosi_in, spi_sclk_in,
                 spi_ncs_in};
      sync_b <= sync_a;
    end
  end

  assign {code_s, ot_s, inl_s, in8_s, inh_s, test_s, ov_s, uv_s,
          ubatt_s, abe_s, rstpin_s, mosi_s, sclk_s, ncs_s} = sync_b;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_d <= 1'b0;
      ncs_d  <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      ncs_d  <= ncs_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic ncs_fall;
  logic ncs_rise;
  logic soft_rst;

  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign ncs_fall  = ~ncs_s & ncs_d;
  assign ncs_rise  = ncs_s & ~ncs_d;
  assign soft_rst  = ~rstpin_s;

  // ---------------------------------------------------------------
  // Serial receive
  // ---------------------------------------------------------------
  lowside_pkg::bit_count_t bit_cnt;
  logic [15:0]             rx;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_cnt <= '0;
      rx      <= '0;
    end else if (ncs_fall) begin
      bit_cnt <= '0;
    end else if (sclk_rise && !ncs_s && bit_cnt != `FRAME_BITS) begin
      bit_cnt <= 5'(bit_cnt + 5'h01);
      rx      <= {rx[14:0], mosi_s};
    end
  end

  logic                    frame_done;
  lowside_pkg::reg_byte_t  frame_cmd;
  logic                    clear_pulse;
  logic                    wr_supply;
  logic                    wr_bus;

  // Writes act only on a frame of at least 16 bits; a short frame is
  // dropped without effect, a longer one acts on its first 16 bits.
  assign frame_done  = ncs_rise && bit_cnt == `FRAME_BITS;
  assign frame_cmd   = rx[15:8];
  assign clear_pulse = frame_done && frame_cmd == `CLEAR_DIAG_CMD;
  assign wr_supply   = frame_done &&
                       frame_cmd == `WRITE_SUPPLY_CONFIG_CMD;
  assign wr_bus      = frame_done && frame_cmd == `WRITE_BUS_CONFIG_CMD;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic ov_latch_en;
  logic thr_select;
  logic thr_disable;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {thr_disable, thr_select, ov_latch_en} <= `SUPPLY_CFG_RESET;
    end else if (soft_rst) begin
      {thr_disable, thr_select, ov_latch_en} <= `SUPPLY_CFG_RESET;
    end else if (wr_supply) begin
      {thr_disable, thr_select, ov_latch_en} <= rx[7:5];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {scb_shutoff_out, bus_multiplex_select_out} <= `BUS_CFG_RESET;
    end else if (soft_rst) begin
      {scb_shutoff_out, bus_multiplex_select_out} <= `BUS_CFG_RESET;
    end else if (wr_bus) begin
      {scb_shutoff_out, bus_multiplex_select_out} <= rx[7:1];
    end
  end

  // Control lines to the analog monitor and the input cells.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pullup_enable_out         <= 1'b1;
      threshold_test_enable_out <= 1'b0;
      threshold_test_select_out <= 1'b1;
    end else begin
      pullup_enable_out         <= bus_multiplex_select_out;
      threshold_test_enable_out <= ~thr_disable;
      threshold_test_select_out <= thr_select;
    end
  end

  // ---------------------------------------------------------------
  // Supply monitoring
  // ---------------------------------------------------------------
  // The stored overvoltage is cleared only by the internal reset or
  // by switching the latch off, never by the reset pin.
  logic ov_stored;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ov_stored <= 1'b0;
    end else if (!ov_latch_en) begin
      ov_stored <= 1'b0;
    end else if (ov_s) begin
      ov_stored <= 1'b1;
    end
  end

  // The enable monitor pin is open drain and is pulled low while the
  // supply is out of range.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      enable_pin_out    <= 1'b0;
      enable_pin_oe_out <= 1'b0;
    end else begin
      enable_pin_out    <= 1'b0;
      enable_pin_oe_out <= ov_s | uv_s | ov_stored;
    end
  end

  // Overtemperature of any stage wins over a simultaneous clear.
  logic ot_flag;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ot_flag <= 1'b1;
    end else if (|ot_s) begin
      ot_flag <= 1'b0;
    end else if (clear_pulse || soft_rst || uv_s) begin
      ot_flag <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Diagnostics
  // ---------------------------------------------------------------
  lowside_pkg::reg_byte_t diag_rdata;
  logic                   any_error;

  diag_register_bank u_diag (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .soft_rst_in   (soft_rst),
    .clear_in      (clear_pulse),
    .code_in       (code_s),
    .ubatt_ok_in   (ubatt_s),
    .addr_in       (rx[2:0]),
    .rdata_out     (diag_rdata),
    .any_error_out (any_error)
  );

  // Stages shut off or limited by a short are released for one cycle
  // so that their filter timers start again.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage_retry_out <= 1'b0;
    end else begin
      stage_retry_out <= clear_pulse;
    end
  end

  // ---------------------------------------------------------------
  // Read data and serial transmit
  // ---------------------------------------------------------------
  lowside_pkg::reg_byte_t status_byte;
  lowside_pkg::reg_byte_t read_byte;
  logic [7:0]             tx;

  assign status_byte = {thr_disable, thr_select, ov_latch_en, ot_flag,
                        ~any_error, abe_s, ~uv_s,
                        ~(ov_s | ov_stored)};

  always_comb begin
    read_byte = 8'h00;
    case (rx[7:0])
      `READ_IDENTIFIER_CMD:    read_byte = CHIP_ID;
      `READ_REVISION_CMD:      read_byte = {SW_REV, MASK_REV};
      `READ_INPUTS_LOW_CMD:
        read_byte = {~in8_s, test_s, 1'b0, inl_s};
      `READ_INPUTS_HIGH_CMD:   read_byte = {1'b0, inh_s};
      `READ_SUPPLY_STATUS_CMD: read_byte = status_byte;
      `READ_BUS_CONFIG_CMD:
        read_byte = {scb_shutoff_out, bus_multiplex_select_out, 1'b1};
      default: begin
        if (rx[7:3] == `READ_DIAG_BASE_CMD >> 3 &&
            rx[2:0] < `DIAG_REG_COUNT) begin
          read_byte = diag_rdata;
        end
      end
    endcase
  end

  // The answer byte is sampled live at the falling edge that follows
  // the last command bit and shifted out on the falling edges.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx           <= '0;
      spi_miso_out <= 1'b0;
    end else if (ncs_fall) begin
      tx           <= '0;
      spi_miso_out <= 1'b0;
    end else if (sclk_fall && !ncs_s) begin
      if (bit_cnt == `CMD_BITS) begin
        spi_miso_out <= read_byte[7];
        tx           <= {read_byte[6:0], 1'b0};
      end else begin
        spi_miso_out <= tx[7];
        tx           <= {tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      spi_miso_oe_out <= 1'b0;
    end else begin
      spi_miso_oe_out <= ~ncs_s;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic load_tx;
  assign load_tx = sclk_fall && !ncs_s && bit_cnt == `CMD_BITS;

  a_ident_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (load_tx && rx[7:0] == `READ_IDENTIFIER_CMD)
    |=> {spi_miso_out, tx[7:1]} == CHIP_ID)
    else $error("identifier byte wrong");

  a_rev_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (load_tx && rx[7:0] == `READ_REVISION_CMD)
    |=> {spi_miso_out, tx[7:1]} == {SW_REV, MASK_REV})
    else $error("revision byte wrong");

  a_inputs_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (load_tx && rx[7:0] == `READ_INPUTS_LOW_CMD)
    |=> spi_miso_out == !$past(in8_s) && tx[7] == $past(test_s) &&
        !tx[6] && tx[5:1] == $past(inl_s))
    else $error("low input byte wrong");

  a_inputs_high: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (load_tx && rx[7:0] == `READ_INPUTS_HIGH_CMD)
    |=> !spi_miso_out && tx[7:1] == $past(inh_s))
    else $error("high input byte wrong");

  a_status_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (load_tx && rx[7:0] == `READ_SUPPLY_STATUS_CMD)
    |=> tx[2] == !$past(uv_s) && tx[3] == $past(abe_s) &&
        tx[4] == !$past(any_error))
    else $error("status byte wrong");

  a_pullup_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_bus && !soft_rst && !rx[`BUS_MUX_BIT])
    |-> ##2 !pullup_enable_out)
    else $error("pull-ups stay on in serial bus mode");

  a_ov_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ov_s && ov_latch_en) |=> ##1 (ov_stored || !$past(ov_latch_en)))
    else $error("overvoltage not stored");

  a_ov_release: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !ov_latch_en |=> !ov_stored)
    else $error("stored overvoltage not released");

  a_ot_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!ot_flag && !clear_pulse && !soft_rst && !uv_s) |=> !ot_flag)
    else $error("overtemperature flag released early");

  a_ot_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (clear_pulse && ot_s == 18'h0) |=> ot_flag)
    else $error("clear did not restore overtemperature flag");

  a_cfg_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_supply && !soft_rst)
    |=> {thr_disable, thr_select, ov_latch_en} == $past(rx[7:5]))
    else $error("supply configuration write lost");

  a_test_enable: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_supply && !soft_rst && !rx[`CFG_DISABLE_BIT])
    |-> ##2 threshold_test_enable_out)
    else $error("threshold test not enabled");

  a_retry_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
    clear_pulse |=> stage_retry_out ##1 !stage_retry_out)
    else $error("stage retry pulse wrong");

endmodule // lowside_switch_status_regs

/* spi_host_model.sv */
// Host model: SPI master, mode 0, 16-bit frames, MSB first.
// Assumes clk_in at 20 MHz; sclk half period is 4 clk (period 400 ns).
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      sclk_out,
  output logic      ncs_out,
  output logic      mosi_out
);
  // ---------------------------------------------------------------
  // Frame driver
  // ---------------------------------------------------------------
  initial begin
    sclk_out = 1'b0;
    ncs_out  = 1'b1;
    mosi_out = 1'b0;
  end
  // Sends command then data and returns the second byte from miso.
  task automatic frame(input logic [7:0] cmd, input logic [7:0] data,
                       output logic [7:0] rdata);
    logic [15:0] word;
    word = {cmd, data};
    @(posedge clk_in) ncs_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      // Data changes with the falling edge, so each bit lasts 8 clk.
      mosi_out <= word[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      if (i < 8) rdata[i] = miso_in;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    ncs_out  <= 1'b1;
    // A released data line must not keep its last value.
    mosi_out <= ~mosi_out;
    repeat (6) @(posedge clk_in);
  endtask
endmodule // spi_host_model

/* lowside_switch_status_regs_tb.sv */
// Self-checking bench of the status register block.
// Assumes the SPI host model and the design files compiled first.
`timescale 1ns/100ps
`include "lowside_consts.svh"
module lowside_switch_status_regs_tb;
  logic        clk_in, nrst_in, rst_n, ncs, sclk, mosi, miso, en_oe;
  logic        en_o, in8, tbit, ov, uv, ubatt, pull, bus_multiplex_select, t_en, t_sel;
  logic        retry;
  logic [4:0]  in_low;
  logic [6:0]  in_high;
  logic [17:0] ot;
  logic [35:0] code;
  logic [5:0]  short_to_battery;
  logic [7:0]  rd;
  int          miscompares, compares, retries;
  // ---------------------------------------------------------------
  // Instances and helpers
  // ---------------------------------------------------------------
  lowside_switch_status_regs u_lowside_switch_status_regs (
    .clk_in(clk_in), .nrst_in(nrst_in), .reset_pin_n_in(rst_n),
    .spi_sclk_in(sclk), .spi_ncs_in(ncs), .spi_mosi_in(mosi),
    .spi_miso_out(miso), .spi_miso_oe_out(),
    .par_in_low_in(in_low), .parallel_input_eight_in(in8),
    .par_in_high_in(in_high), .serial_bus_test_bit_in(tbit),
    .overvoltage_in(ov), .undervoltage_in(uv), .ubatt_ok_in(ubatt),
    .overtemperature_in(ot), .stage_code_in(code),
    .enable_pin_in(en_oe ? en_o : 1'b1), .enable_pin_out(en_o),
    .enable_pin_oe_out(en_oe), .pullup_enable_out(pull),
    .bus_multiplex_select_out(bus_multiplex_select), .scb_shutoff_out(short_to_battery),
    .threshold_test_enable_out(t_en),
    .threshold_test_select_out(t_sel), .stage_retry_out(retry));
  spi_host_model u_spi_host_model (.clk_in(clk_in), .miso_in(miso),
    .sclk_out(sclk), .ncs_out(ncs), .mosi_out(mosi));
  function automatic logic [7:0] st(input logic [2:0] cfg,
    input logic ot_ok, err_ok, pin, uv_ok, ov_ok);
    return {cfg, ot_ok, err_ok, pin, uv_ok, ov_ok};
  endfunction
  task automatic check(input string name, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic xfer(input logic [7:0] c, input logic [7:0] d);
    u_spi_host_model.frame(c, d, rd);
  endtask
  task automatic stat(input logic [7:0] e);
    xfer(`READ_SUPPLY_STATUS_CMD, 8'h00);
    check("status", rd, e);
  endtask
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) if (retry === 1'b1) retries++;
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    test_done();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {nrst_in, rst_n, in8, tbit, ov, uv, ubatt} = 7'b0100001;
    {in_low, in_high, ot} = '0;
    code = '1;
    void'($urandom(87));
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    xfer(`READ_IDENTIFIER_CMD, 8'h00);
    check("ident", rd, 8'h5a);
    xfer(`READ_REVISION_CMD, 8'h00);
    check("revision", rd, 8'h32);
    stat(st(3'h7, 1, 1, 1, 1, 1));
    check("test", {6'h0, t_en, t_sel}, 8'h01);
    xfer(8'h3c, 8'h00);
    check("unknown", rd, 8'h00);
    for (int n = 0; n < 6; n++) begin
      {in8, tbit, in_high, in_low} <= (n == 0) ? 14'h3fff : 14'($urandom);
      ubatt <= 1'($urandom);
      repeat (4) @(posedge clk_in);
      xfer(`READ_INPUTS_LOW_CMD, 8'h00);
      check("in_low", rd, {~in8, tbit, 1'b0, in_low});
      xfer(`READ_INPUTS_HIGH_CMD, 8'h00);
      check("in_high", rd, {1'b0, in_high});
    end
    ov <= 1'b1;
    repeat (8) @(posedge clk_in);
    ov <= 1'b0;
    repeat (8) @(posedge clk_in);
    stat(st(3'h7, 1, 1, 0, 1, 0));
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_in);
    stat(st(3'h7, 1, 1, 0, 1, 0));
    xfer(`WRITE_SUPPLY_CONFIG_CMD, 8'h1f);
    stat(st(3'h0, 1, 1, 1, 1, 1));
    check("test", {6'h0, t_en, t_sel}, 8'h02);
    ov <= 1'b1;
    repeat (8) @(posedge clk_in);
    ov <= 1'b0;
    repeat (8) @(posedge clk_in);
    stat(st(3'h0, 1, 1, 1, 1, 1));
    xfer(`WRITE_SUPPLY_CONFIG_CMD, 8'he0);
    ot[5] <= 1'b1;
    repeat (8) @(posedge clk_in);
    {ot[5], uv} <= 2'b01;
    repeat (8) @(posedge clk_in);
    stat(st(3'h7, 1, 1, 0, 0, 1));
    uv <= 1'b0;
    code[1:0] <= 2'h2;
    ot[0] <= 1'b1;
    repeat (8) @(posedge clk_in);
    ot[0] <= 1'b0;
    stat(st(3'h7, 0, 0, 1, 1, 1));
    xfer(`CLEAR_DIAG_CMD, 8'($urandom));
    stat(st(3'h7, 1, 0, 1, 1, 1));
    code <= '1;
    xfer(`CLEAR_DIAG_CMD, 8'($urandom));
    stat(st(3'h7, 1, 1, 1, 1, 1));
    xfer(`READ_DIAG_BASE_CMD, 8'h00);
    check("diag", rd, 8'hff);
    xfer(`READ_DIAG_BASE_CMD + 8'h04, 8'h00);
    check("diag5", rd, {3'h7, ubatt, 4'hf});
    check("retries", 8'(retries), 8'h02);
    xfer(`WRITE_BUS_CONFIG_CMD, 8'h01);
    check("bus_mux", {6'h0, bus_multiplex_select, pull}, 8'h00);
    xfer(`READ_BUS_CONFIG_CMD, 8'h00);
    check("bus_cfg", rd, 8'h01);
    xfer(`WRITE_BUS_CONFIG_CMD, 8'hff);
    check("bus_mux", {6'h0, bus_multiplex_select, pull}, 8'h03);
    test_done();
  end
endmodule // lowside_switch_status_regs_tb
